// ==== src/synth_cfg_pkg.sv ====
// constants for the serial configuration register bank of the synthesizer
// assumes: included before the bank module; no other dependencies
//
// Contract
// - incoming bits are held in a 24-bit shift register before any commit
// - words arrive most significant bit first and shift toward the high end
// - data is sampled and the shift register advances on each serial clock rise
// - a rising load strobe copies the shift register into the addressed word
// - the low address bits of the word select the destination word
// - low address bits 00 route the word into the RF divider word
// - word zero bit 23 picks built-in or programmed IF counters
// - word zero bit 21 low forces lock output low, high shows lock status
// - word zero holds variant select, fixed zero, program, swallow, fraction fields
// - lock rises after four good comparisons in a row, drops on a bad one
// - low address bits 01 route the word into the synthesizer config word
package synth_cfg_pkg;

  // -----------------------------------------------------------
  // word geometry and destination indices
  // -----------------------------------------------------------
  localparam int unsigned WORD_W = 24;
  localparam int unsigned NUM_WORDS = 7;
  localparam int unsigned IDX_W = 3;
  localparam logic [2:0] RF_DIVIDER_IDX = 3'h0;
  localparam logic [2:0] SYNTH_CONFIG_IDX = 3'h1;
  localparam logic [2:0] IF_PUMP_CURRENT_IDX = 3'h2;
  localparam logic [2:0] LOOP_BANDWIDTH_IDX = 3'h3;
  localparam logic [2:0] IF_MAIN_DIVIDER_IDX = 3'h4;
  localparam logic [2:0] IF_REFERENCE_DIVIDER_IDX = 3'h5;
  localparam logic [2:0] AUXILIARY_FIXED_IDX = 3'h6;
  localparam logic [23:0] WORD_RESET = 24'h00_0000;

  // -----------------------------------------------------------
  // rf divider word field positions
  // -----------------------------------------------------------
  localparam int unsigned DEFAULT_SEL_BIT = 23;
  localparam int unsigned VCO_VARIANT_BIT = 22;
  localparam int unsigned LOCK_OUT_EN_BIT = 21;
  localparam int unsigned FIXED_ZERO_BIT = 20;
  localparam int unsigned PROG_LSB = 16;
  localparam int unsigned PROG_W = 4;
  localparam int unsigned SWALLOW_LSB = 13;
  localparam int unsigned SWALLOW_W = 3;
  localparam int unsigned FRACTION_LSB = 2;
  localparam int unsigned FRACTION_W = 11;

  // -----------------------------------------------------------
  // if counter field positions in words four and five
  // -----------------------------------------------------------
  localparam int unsigned IF_SWALLOW_LSB = 13;
  localparam int unsigned IF_SWALLOW_W = 4;
  localparam int unsigned IF_PROG_LSB = 4;
  localparam int unsigned IF_PROG_W = 9;
  localparam int unsigned IF_REF_LSB = 5;
  localparam int unsigned IF_REF_W = 9;

  // -----------------------------------------------------------
  // lock detector
  // -----------------------------------------------------------
  localparam int unsigned LOCK_GOOD_COUNT = 4;
  localparam logic [2:0] LOCK_CNT_MAX = 3'h4;

endpackage

// ==== src/serial_synth_config_regs.sv ====
// serial configuration interface and control word bank of the synthesizer
// assumes: SCLK and SDATA come from the host; the host leaves SCLK idle
// while the load strobe is high and for three CORE_CLK cycles after its rise
`timescale 1ns/10ps
`default_nettype none

module serial_synth_config_regs
  import synth_cfg_pkg::*;
#(
  parameter logic [3:0] DEF_IF_SWALLOW = 4'h0, // built-in if swallow count
  parameter logic [8:0] DEF_IF_PROGRAM = 9'h001, // built-in if program count
  parameter logic [8:0] DEF_IF_REFERENCE = 9'h002 // built-in if reference count
) (
  input wire logic CORE_CLK, // core clock, 100 MHz
  input wire logic RESET_N, // async reset, active low
  input wire logic SCLK, // serial clock from host
  input wire logic SDATA, // serial data, valid on SCLK rise
  input wire logic LOAD_STROBE, // load strobe, async pin
  input wire logic CMP_VALID, // one-cycle pulse per phase comparison
  input wire logic CMP_ERR_SMALL, // phase error under threshold
  output logic [23:0] CTRL_WORD [NUM_WORDS], // committed control words
  output logic COMMIT_PULSE, // one-cycle pulse, rises on the same edge as each commit
  output logic [2:0] COMMIT_IDX, // index of last committed word
  output logic USE_DEFAULT_IF, // built-in if counters in use
  output logic VCO_VARIANT_SELECT, // vco variant choice
  output logic [3:0] RF_PROGRAM_COUNT, // rf program count
  output logic [2:0] RF_SWALLOW_COUNT, // rf swallow count
  output logic [10:0] RF_FRACTION_NUMERATOR, // rf fraction numerator
  output logic [3:0] IF_SWALLOW_COUNT, // effective if swallow count
  output logic [8:0] IF_PROGRAM_COUNT, // effective if program count
  output logic [8:0] IF_REFERENCE_COUNT, // effective if reference count
  output logic LOCK_INDICATOR // lock pin level
);

  // -----------------------------------------------------------
  // link side: shift register on the serial clock
  // -----------------------------------------------------------
  logic [23:0] shift_q;
  logic [23:0] shift_d;

  // msb first: each new bit enters at bit 0, older bits move up
  assign shift_d = {shift_q[22:0], SDATA};

  // data pin is synchronous to SCLK, so no synchroniser here
  always_ff @(posedge SCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      shift_q <= WORD_RESET;
    end else begin
      shift_q <= shift_d;
    end
  end

  // -----------------------------------------------------------
  // strobe crossing into the core domain
  // -----------------------------------------------------------
  logic strobe_s1_q;
  logic strobe_s2_q;
  logic strobe_s3_q;
  logic strobe_rise;

  // the shift word is held still by the host while the strobe is high,
  // so the strobe itself qualifies the word crossing
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strobe_s1_q <= 1'b0;
      strobe_s2_q <= 1'b0;
      strobe_s3_q <= 1'b0;
    end else begin
      strobe_s1_q <= LOAD_STROBE;
      strobe_s2_q <= strobe_s1_q;
      strobe_s3_q <= strobe_s2_q;
    end
  end

  // only a low-to-high edge commits
  assign strobe_rise = strobe_s2_q & ~strobe_s3_q;

  // -----------------------------------------------------------
  // destination decode from the low address bits
  // -----------------------------------------------------------
  logic [2:0] dest_idx;
  logic [4:0] addr_bits;

  assign addr_bits = shift_q[4:0];
  // low pairs 00/01/10 pick words zero to two; 11 extends the code upward
  assign dest_idx = (addr_bits[1:0] == 2'h0) ? RF_DIVIDER_IDX :
                    (addr_bits[1:0] == 2'h1) ? SYNTH_CONFIG_IDX :
                    (addr_bits[1:0] == 2'h2) ? IF_PUMP_CURRENT_IDX :
                    (addr_bits[2] == 1'b0) ? LOOP_BANDWIDTH_IDX :
                    (addr_bits[3] == 1'b0) ? IF_MAIN_DIVIDER_IDX :
                    (addr_bits[4] == 1'b0) ? IF_REFERENCE_DIVIDER_IDX :
                    AUXILIARY_FIXED_IDX;

  // -----------------------------------------------------------
  // control word bank
  // -----------------------------------------------------------
  logic [23:0] words_q [NUM_WORDS];

  // one flop row per word, written only on its own strobe edge
  for (genvar gi = 0; gi < NUM_WORDS; gi++) begin : g_word
    logic hit;
    assign hit = strobe_rise & (dest_idx == 3'(gi));
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        words_q[gi] <= WORD_RESET;
      end else if (hit) begin
        words_q[gi] <= shift_q;
      end
    end
  end

  assign CTRL_WORD = words_q;

  // commit notice for software-facing logic
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      COMMIT_PULSE <= 1'b0;
      COMMIT_IDX <= RF_DIVIDER_IDX;
    end else begin
      COMMIT_PULSE <= strobe_rise;
      COMMIT_IDX <= strobe_rise ? dest_idx : COMMIT_IDX;
    end
  end

  // -----------------------------------------------------------
  // rf divider word fields and if counter source
  // -----------------------------------------------------------
  logic [23:0] rf_word;
  logic use_def;
  logic [3:0] if_sw_d;
  logic [8:0] if_pr_d;
  logic [8:0] if_rf_d;

  assign rf_word = words_q[RF_DIVIDER_IDX];
  assign use_def = rf_word[DEFAULT_SEL_BIT];
  // programmed counters only matter once the default select is cleared
  assign if_sw_d = use_def ? DEF_IF_SWALLOW :
                   words_q[IF_MAIN_DIVIDER_IDX][IF_SWALLOW_LSB +: IF_SWALLOW_W];
  assign if_pr_d = use_def ? DEF_IF_PROGRAM :
                   words_q[IF_MAIN_DIVIDER_IDX][IF_PROG_LSB +: IF_PROG_W];
  assign if_rf_d = use_def ? DEF_IF_REFERENCE :
                   words_q[IF_REFERENCE_DIVIDER_IDX][IF_REF_LSB +: IF_REF_W];

  // fields registered once more so outputs come straight from flops
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      USE_DEFAULT_IF <= 1'b0;
      VCO_VARIANT_SELECT <= 1'b0;
      RF_PROGRAM_COUNT <= 4'h0;
      RF_SWALLOW_COUNT <= 3'h0;
      RF_FRACTION_NUMERATOR <= 11'h000;
      IF_SWALLOW_COUNT <= 4'h0;
      IF_PROGRAM_COUNT <= 9'h000;
      IF_REFERENCE_COUNT <= 9'h000;
    end else begin
      USE_DEFAULT_IF <= use_def;
      VCO_VARIANT_SELECT <= rf_word[VCO_VARIANT_BIT];
      RF_PROGRAM_COUNT <= rf_word[PROG_LSB +: PROG_W];
      RF_SWALLOW_COUNT <= rf_word[SWALLOW_LSB +: SWALLOW_W];
      RF_FRACTION_NUMERATOR <= rf_word[FRACTION_LSB +: FRACTION_W];
      IF_SWALLOW_COUNT <= if_sw_d;
      IF_PROGRAM_COUNT <= if_pr_d;
      IF_REFERENCE_COUNT <= if_rf_d;
    end
  end

  // -----------------------------------------------------------
  // lock detector and lock pin
  // -----------------------------------------------------------
  logic [2:0] good_cnt_q;
  logic [2:0] good_cnt_d;
  logic locked_q;
  logic locked_d;

  // saturating run of good comparisons; any bad one restarts the run
  assign good_cnt_d = !CMP_VALID ? good_cnt_q :
                      !CMP_ERR_SMALL ? 3'h0 :
                      (good_cnt_q == LOCK_CNT_MAX) ? good_cnt_q :
                      good_cnt_q + 3'h1;
  assign locked_d = (good_cnt_d == LOCK_CNT_MAX);

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      good_cnt_q <= 3'h0;
      locked_q <= 1'b0;
      LOCK_INDICATOR <= 1'b0;
    end else begin
      good_cnt_q <= good_cnt_d;
      locked_q <= locked_d;
      // disabled pin is held at ground regardless of lock
      LOCK_INDICATOR <= rf_word[LOCK_OUT_EN_BIT] & locked_d;
    end
  end

  // -----------------------------------------------------------
  // assertions
  // -----------------------------------------------------------
  shift_msb_a: assert property (
    @(posedge SCLK) disable iff (!RESET_N)
    1'b1 |=> shift_q == {$past(shift_q[22:0]), $past(SDATA)})
    else $error("shift register did not take new bit at bit zero");

  commit_rf_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    strobe_rise && shift_q[1:0] == 2'h0 |=> words_q[0] == $past(shift_q))
    else $error("rf divider word not loaded on strobe");

  commit_cfg_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    strobe_rise && shift_q[1:0] == 2'h1 |=> words_q[1] == $past(shift_q) && $stable(words_q[0]))
    else $error("config word not loaded or wrong word hit");

  commit_aux_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    strobe_rise && shift_q[4:0] == 5'h1f |=> words_q[6] == $past(shift_q) && $stable(words_q[5]))
    else $error("auxiliary word decode wrong");

  // the codes of words two to five each land in their own row and leave the next row unchanged
  commit_pump_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    strobe_rise && shift_q[1:0] == 2'h2 |=> words_q[2] == $past(shift_q) && $stable(words_q[3]))
    else $error("pump current word decode wrong");

  commit_loop_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    strobe_rise && shift_q[2:0] == 3'h3 |=> words_q[3] == $past(shift_q) && $stable(words_q[4]))
    else $error("loop bandwidth word decode wrong");

  commit_main_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    strobe_rise && shift_q[3:0] == 4'h7 |=> words_q[4] == $past(shift_q) && $stable(words_q[5]))
    else $error("if main divider word decode wrong");

  commit_ref_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    strobe_rise && shift_q[4:0] == 5'h0f |=> words_q[5] == $past(shift_q) && $stable(words_q[6]))
    else $error("if reference divider word decode wrong");

  commit_note_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    strobe_rise |=> COMMIT_PULSE && COMMIT_IDX == $past(dest_idx))
    else $error("commit notice missing or wrong index");

  no_strobe_hold_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    !strobe_rise |=> $stable(words_q[0]) && $stable(words_q[1]) && $stable(words_q[2]) && $stable(words_q[3])
      && $stable(words_q[4]) && $stable(words_q[5]) && $stable(words_q[6]))
    else $error("control word changed without strobe");

  strobe_edge_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    strobe_rise |-> $past(LOAD_STROBE, 2) && !$past(LOAD_STROBE, 3))
    else $error("commit without strobe edge");

  lock_gnd_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    !rf_word[LOCK_OUT_EN_BIT] |=> !LOCK_INDICATOR)
    else $error("lock pin not grounded when disabled");

  lock_rise_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    good_cnt_q == 3'h3 && CMP_VALID && CMP_ERR_SMALL && rf_word[LOCK_OUT_EN_BIT] |=> LOCK_INDICATOR)
    else $error("lock did not rise after four good comparisons");

  lock_drop_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    CMP_VALID && !CMP_ERR_SMALL |=> !locked_q && !LOCK_INDICATOR && good_cnt_q == 3'h0)
    else $error("lock held after a bad comparison");

  if_source_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    use_def |=> IF_PROGRAM_COUNT == DEF_IF_PROGRAM && IF_REFERENCE_COUNT == DEF_IF_REFERENCE)
    else $error("built-in if counters not selected");

  rf_fields_a: assert property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    1'b1 |=> RF_FRACTION_NUMERATOR == $past(rf_word[12:2]) && RF_PROGRAM_COUNT == $past(rf_word[19:16]))
    else $error("rf divider fields misplaced");

  cover_rf_load_c: cover property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    strobe_rise && dest_idx == RF_DIVIDER_IDX);

  cover_aux_load_c: cover property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    strobe_rise && dest_idx == AUXILIARY_FIXED_IDX);

  cover_lock_c: cover property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(LOCK_INDICATOR));

  cover_prog_if_c: cover property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    $fell(USE_DEFAULT_IF));

  cover_unlock_c: cover property (
    @(posedge CORE_CLK) disable iff (!RESET_N)
    $fell(LOCK_INDICATOR));

endmodule // serial_synth_config_regs

`default_nettype wire

// ==== test/host_link_model.sv ====
// host side of the three-wire serial link: clock, data and load strobe
// assumes: the bench calls send() by hierarchical name, one frame at a time
`timescale 1ns/10ps
`default_nettype none

module host_link_model (
  output var logic SCLK, // serial clock, still between frames
  output var logic SDATA, // serial data
  output var logic LOAD_STROBE // load strobe
);
  // ------------------------------------------------
  // frame sender, 32 ns serial clock
  // ------------------------------------------------
  initial begin
    SCLK = 1'b0;
    SDATA = 1'b0;
    LOAD_STROBE = 1'b0;
  end

  // data moves while the clock is low, so it is settled at each rise
  task automatic send(input logic [23:0] w, input logic commit);
    #7;
    for (int i = 23; i >= 0; i--) begin
      SDATA = w[i];
      #16 SCLK = 1'b1;
      #16 SCLK = 1'b0;
    end
    SDATA = ~SDATA; // a released line must not keep the last bit
    #16 LOAD_STROBE = commit;
    #100 LOAD_STROBE = 1'b0; // clock stays idle while the word crosses
    #40;
  endtask
endmodule // host_link_model

`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the serial control word bank
// assumes: host_link_model drives the link; lock comparisons come from here
`timescale 1ns/10ps
`default_nettype none

module tb;
  import synth_cfg_pkg::*;
  localparam logic [3:0] DSW = 4'h9; // built-in counts, arbitrary
  localparam logic [8:0] DPG = 9'h0E5;
  localparam logic [8:0] DRF = 9'h0A0;
  logic clk, rst_n, sclk, sdata, strobe, cmp_v, cmp_ok;
  logic commit_p, use_def, vco_sel, lock;
  logic [2:0] cidx, rf_sw;
  logic [3:0] rf_pg, if_sw;
  logic [10:0] rf_fr;
  logic [8:0] if_pg, if_rf;
  logic [23:0] words [NUM_WORDS];
  logic [23:0] shadow [NUM_WORDS];
  logic [26:0] exp_q [$];
  logic [26:0] note;
  int mismatches, samples_checked, cycles;
  integer seed = 43943;

  serial_synth_config_regs #(.DEF_IF_SWALLOW(DSW), .DEF_IF_PROGRAM(DPG), .DEF_IF_REFERENCE(DRF)) DUT (
    .CORE_CLK(clk), .RESET_N(rst_n), .SCLK(sclk), .SDATA(sdata), .LOAD_STROBE(strobe),
    .CMP_VALID(cmp_v), .CMP_ERR_SMALL(cmp_ok), .CTRL_WORD(words), .COMMIT_PULSE(commit_p),
    .COMMIT_IDX(cidx), .USE_DEFAULT_IF(use_def), .VCO_VARIANT_SELECT(vco_sel),
    .RF_PROGRAM_COUNT(rf_pg), .RF_SWALLOW_COUNT(rf_sw), .RF_FRACTION_NUMERATOR(rf_fr),
    .IF_SWALLOW_COUNT(if_sw), .IF_PROGRAM_COUNT(if_pg), .IF_REFERENCE_COUNT(if_rf),
    .LOCK_INDICATOR(lock));

  host_link_model host (.SCLK(sclk), .SDATA(sdata), .LOAD_STROBE(strobe));

  // ------------------------------------------------
  // clock, compare, verdict
  // ------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // legal words only: address code, fixed bits and host limits kept
  function automatic logic [23:0] mk(input int idx, input logic [23:0] r);
    case (idx)
      1: return {r[23:2], 2'b01};
      2: return {r[23:2], 2'b10};
      3: return {r[23:3], 3'b011};
      4: return {7'b000_1000, r[16:4], 4'b0111};
      5: return {10'b00_1100_0010, r[13:5], 5'b0_1111};
      6: return 24'h80_001F;
      default: return {r[23:21], 1'b0, 4'(2 + r[19:16] % 14), 3'(r[15:13] % 6), 11'(r[12:2] % 1920), 2'b00};
    endcase
  endfunction

  // note the expected commit first, then send the frame
  task automatic wr(input int idx, input logic [23:0] w);
    exp_q.push_back({3'(idx), w});
    shadow[idx] = w;
    host.send(w, 1'b1);
    repeat (3) @(posedge clk);
  endtask

  task automatic fields;
    logic [23:0] w0;
    w0 = shadow[0];
    check(use_def, w0[23]);
    check(vco_sel, w0[22]);
    check(rf_pg, w0[19:16]);
    check(rf_sw, w0[15:13]);
    check(rf_fr, w0[12:2]);
    check(if_sw, w0[23] ? DSW : shadow[4][16:13]);
    check(if_pg, w0[23] ? DPG : shadow[4][12:4]);
    check(if_rf, w0[23] ? DRF : shadow[5][13:5]);
  endtask

  task automatic cmp(input int n, input logic ok);
    repeat (n) begin
      cmp_v <= 1'b1;
      cmp_ok <= ok;
      @(posedge clk);
      cmp_v <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  // commit watcher: every pulse takes the oldest note; none left is a stray commit
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
    if (commit_p === 1'b1) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0);
      else begin
        note = exp_q.pop_front();
        check(cidx, note[26:24]);
        check(words[note[26:24]], note[23:0]);
      end
    end
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    rst_n = 1'b0;
    cmp_v = 1'b0;
    cmp_ok = 1'b0;
    for (int i = 0; i < 7; i++) shadow[i] = WORD_RESET;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) check(words[i], WORD_RESET);
    // start-up load three down to zero, built-in counters
    for (int i = 3; i >= 0; i--) wr(i, i == 0 ? mk(0, 24'($random(seed))) | 24'h80_0000 : mk(i, 24'($random(seed))));
    fields();
    // own counters: six down to zero with default select cleared
    for (int i = 6; i >= 0; i--) wr(i, i == 0 ? mk(0, 24'($random(seed))) & 24'h7F_FFFF : mk(i, 24'($random(seed))));
    fields();
    // retune through word zero only, either counter source
    repeat (4) begin
      wr(0, mk(0, 24'($random(seed))));
      fields();
    end
    // a frame without strobe commits nothing; only the last 24 bits count
    host.send(24'($random(seed)), 1'b0);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 7; i++) check(words[i], shadow[i]);
    wr(1, mk(1, 24'($random(seed))));
    // lock detector needs four good comparisons in a row
    wr(0, shadow[0] | 24'h20_0000);
    cmp(3, 1'b1);
    cmp(1, 1'b0);
    cmp(3, 1'b1);
    check(lock, 1'b0);
    cmp(1, 1'b1);
    check(lock, 1'b1);
    cmp(1, 1'b0);
    check(lock, 1'b0);
    cmp(4, 1'b1);
    wr(0, shadow[0] & 24'hDF_FFFF);
    check(lock, 1'b0);
    wr(0, shadow[0] | 24'h20_0000);
    check(lock, 1'b1);
    // a note still queued means a strobe rise never produced its commit
    check(24'(exp_q.size()), 24'h00_0000);
    print_verdict();
  end
endmodule // tb

`default_nettype wire
